// ==== hric_ctrl.sv ====
`timescale 1ns/1ns
module hric_ctrl
  import hric_pkg::*;
#(
  parameter int RST_HOLD_CYC = RST_MIN_CYC
) (
  input  wire logic              sys_clk,
  input  wire logic              arst_n,
  // reset causes
  input  wire logic              reset_pin,
  input  wire logic              power_on_det,
  input  wire logic              osc_stop_det,
  // external request pins
  input  wire logic [3:0]        port_b_group,
  input  wire logic              port_e_bit3,
  input  wire logic [3:0]        port_f_group,
  input  wire logic [3:0]        port_zero_group,
  // internal request pulses
  input  wire logic              watchdog_request,
  input  wire logic              melody_end_request,
  input  wire logic              speech_request,
  input  wire logic              timer_zero_request,
  input  wire logic              timer_one_request,
  input  wire logic              timer_two_request,
  input  wire logic              timer_three_request,
  input  wire logic              shifter_request,
  input  wire logic              ten_hertz_request,
  input  wire logic              thirty_two_hertz_request,
  input  wire logic              sixteen_hertz_request,
  input  wire logic              four_hertz_request,
  input  wire logic              two_hertz_request,
  input  wire logic              melody_data_request,
  // cpu core strobes
  input  wire logic              halt_second_machine_state,
  input  wire logic              irq_accept,
  input  wire logic              return_from_interrupt_instr,
  input  wire logic              enable_instr,
  input  wire logic              disable_instr,
  // cpu core outputs
  output logic                   cpu_irq,
  output logic [15:0]            irq_vector,
  output logic                   cpu_run,
  output logic                   pc_hold,
  output logic                   fetch_start,
  output logic [15:0]            fetch_addr,
  output logic                   cpu_init,
  output logic                   melody_xfer,
  output logic                   halt_latch_flag,
  output logic                   master_irq_gate,
  output logic                   backup_flag,
  output logic                   backup_on,
  output logic                   bias_reference_supply,
  output logic                   seg_off_gnd,
  // axi4-lite slave
  input  wire logic [7:0]        s_axi_awaddr,
  input  wire logic              s_axi_awvalid,
  output logic                   s_axi_awready,
  input  wire logic [31:0]       s_axi_wdata,
  input  wire logic [3:0]        s_axi_wstrb,
  input  wire logic              s_axi_wvalid,
  output logic                   s_axi_wready,
  output logic [1:0]             s_axi_bresp,
  output logic                   s_axi_bvalid,
  input  wire logic              s_axi_bready,
  input  wire logic [7:0]        s_axi_araddr,
  input  wire logic              s_axi_arvalid,
  output logic                   s_axi_arready,
  output logic [31:0]            s_axi_rdata,
  output logic [1:0]             s_axi_rresp,
  output logic                   s_axi_rvalid,
  input  wire logic              s_axi_rready
);

  // highest-priority set bit, lowest index wins
  function automatic logic [4:0] pick_first(input logic [N_SRC-1:0] v);
    logic [4:0] idx;
    idx = 5'd0;
    for (int i = N_SRC - 1; i >= 0; i--) begin
      if (v[i]) idx = 5'(i);
    end
    return idx;
  endfunction : pick_first

  hric_state_t             state;
  logic [N_SRC-1:0]        request_latch_regs;
  logic [N_SRC-1:0]        source_enable_regs;
  logic [N_SRC-1:0]        raw_req;
  logic [N_SRC-1:0]        raw_prev;
  logic [N_SRC-1:0]        src_event;
  logic [N_SRC-1:0]        en_eff;
  logic [N_SRC-1:0]        fwd;
  logic [N_SRC-1:0]        wake;
  logic [N_SRC-1:0]        sw_clear;
  logic [N_SRC-1:0]        take_clear;
  logic [4:0]              sel;
  logic                    rst_src;
  logic                    in_reset;
  logic [31:0]             hold_cnt;
  logic                    aw_have;
  logic                    w_have;
  logic [7:0]              aw_addr;
  logic [31:0]             w_data;
  logic [3:0]              w_strb;
  logic                    wr_go;

  // three reset causes, any one enters reset
  assign rst_src  = reset_pin | power_on_det | osc_stop_det;
  assign in_reset = (state == HRIC_RESET);

  // source vector in priority order
  assign raw_req = {two_hertz_request, four_hertz_request, sixteen_hertz_request,
                    thirty_two_hertz_request, ten_hertz_request, shifter_request,
                    timer_three_request, timer_two_request, timer_one_request, timer_zero_request,
                    |port_zero_group, |port_f_group, port_e_bit3, speech_request,
                    |port_b_group, melody_end_request, watchdog_request};

  // pins are levels: latch on their rising edge only
  assign src_event = raw_req & ~raw_prev;

  // watchdog always counts as enabled
  assign en_eff = source_enable_regs | N_SRC'(1);
  assign wake   = request_latch_regs & en_eff;
  // master gate applies to all but the watchdog
  assign fwd    = wake & (master_irq_gate ? '1 : N_SRC'(1));
  assign sel    = pick_first(fwd);

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      raw_prev <= '0;
    end else begin
      raw_prev <= raw_req;
    end
  end
  // operating state machine
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      state    <= HRIC_RESET;
      hold_cnt <= '0;
    end else if (rst_src) begin
      state    <= HRIC_RESET;
      hold_cnt <= '0;
    end else begin
      case (state)
        HRIC_RESET: begin
          // reset processing lasts at least the minimum pulse time
          if (hold_cnt >= 32'(RST_HOLD_CYC)) state <= HRIC_RUN;
          else hold_cnt <= hold_cnt + 32'd1;
        end
        HRIC_RUN: begin
          // pending request turns halt into an idle instruction
          if (halt_second_machine_state && !(|fwd)) state <= HRIC_HALT;
        end
        HRIC_HALT: begin
          if (|wake) state <= HRIC_RUN;
          else if (melody_data_request) state <= HRIC_MEL_STEP;
        end
        HRIC_MEL_STEP: state <= HRIC_MEL_XFER;
        HRIC_MEL_XFER: state <= HRIC_HALT;
        default: state <= HRIC_RESET;
      endcase
    end
  end
  // halt flag mirrors the halt state, melody steps included
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      halt_latch_flag <= 1'b0;
    end else if (rst_src || in_reset) begin
      halt_latch_flag <= 1'b0;
    end else if (state == HRIC_HALT && (|wake)) begin
      halt_latch_flag <= 1'b0;
    end else if (state == HRIC_RUN && halt_second_machine_state && !(|fwd)) begin
      halt_latch_flag <= 1'b1;
    end
  end

  // cpu run control; clock and time base are outside and never gated
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      cpu_run     <= 1'b0;
      pc_hold     <= 1'b1;
      melody_xfer <= 1'b0;
      fetch_start <= 1'b0;
      fetch_addr  <= START_ADDR;
    end else begin
      cpu_run     <= !rst_src && (state == HRIC_RUN || state == HRIC_MEL_STEP);
      pc_hold     <= rst_src || state == HRIC_RESET || state == HRIC_HALT
                     || state == HRIC_MEL_XFER;
      melody_xfer <= !rst_src && state == HRIC_MEL_XFER; // step first, then transfer
      fetch_start <= !rst_src && in_reset && hold_cnt >= 32'(RST_HOLD_CYC);
      fetch_addr  <= START_ADDR;
    end
  end
  // reset side effects held for the whole reset state
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      cpu_init              <= 1'b1;
      backup_on             <= 1'b1;
      bias_reference_supply <= 1'b1;
      seg_off_gnd           <= 1'b1;
    end else begin
      cpu_init              <= rst_src || in_reset;
      backup_on             <= rst_src || in_reset;
      bias_reference_supply <= rst_src || in_reset;
      seg_off_gnd           <= rst_src || in_reset;
    end
  end
  // backup flag set by reset, cleared by software only
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      backup_flag <= 1'b1;
    end else if (rst_src || in_reset) begin
      backup_flag <= 1'b1;
    end else if (wr_go && aw_addr == ADDR_STATUS && w_strb[0] && w_data[ST_BACKUP_BIT]) begin
      backup_flag <= 1'b0;
    end
  end
  // master gate: cleared on accept and reset, set by return
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      master_irq_gate <= 1'b0;
    end else if (rst_src || in_reset) begin
      master_irq_gate <= 1'b0;
    end else if (irq_accept && cpu_irq) begin
      master_irq_gate <= 1'b0;
    end else if (return_from_interrupt_instr || enable_instr) begin
      master_irq_gate <= 1'b1;
    end else if (disable_instr) begin
      master_irq_gate <= 1'b0;
    end
  end

  // clear the latch of the source the cpu took, or by software
  assign take_clear = (irq_accept && cpu_irq) ? (N_SRC'(1) << sel) : '0;
  assign sw_clear   = (wr_go && aw_addr == ADDR_REQUEST) ? w_data[N_SRC-1:0] : '0;

  // request latches; a new event beats a same-cycle clear
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      request_latch_regs <= '0;
    end else if (rst_src || in_reset) begin
      request_latch_regs <= '0;
    end else begin
      request_latch_regs <= (request_latch_regs & ~(take_clear | sw_clear)) | src_event;
    end
  end
  // request to the core only while running; vector follows the selection every cycle
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      cpu_irq    <= 1'b0;
      irq_vector <= VEC_TABLE[0];
    end else begin
      cpu_irq    <= !rst_src && state == HRIC_RUN && (|fwd) && !(irq_accept && cpu_irq);
      irq_vector <= VEC_TABLE[sel];
    end
  end

  // write channel capture, address and data in either order
  assign wr_go = aw_have && w_have && !s_axi_bvalid;

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      aw_have       <= 1'b0;
      w_have        <= 1'b0;
      aw_addr       <= '0;
      w_data        <= '0;
      w_strb        <= '0;
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= RESP_OKAY;
    end else begin
      s_axi_awready <= !aw_have && !(s_axi_awvalid && s_axi_awready);
      s_axi_wready  <= !w_have && !(s_axi_wvalid && s_axi_wready);
      if (s_axi_awvalid && s_axi_awready) begin
        aw_have <= 1'b1;
        aw_addr <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_have <= 1'b1;
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
      end
      if (wr_go) begin
        aw_have      <= 1'b0;
        w_have       <= 1'b0;
        s_axi_bvalid <= 1'b1;
        // unmapped or read-only targets answer slverr
        s_axi_bresp  <= (aw_addr == ADDR_ENABLE || aw_addr == ADDR_REQUEST
                         || aw_addr == ADDR_STATUS) ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end
  // enable register; byte lanes honoured, watchdog bit ignored
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      source_enable_regs <= ENABLE_RST;
    end else if (rst_src || in_reset) begin
      source_enable_regs <= ENABLE_RST;
    end else if (wr_go && aw_addr == ADDR_ENABLE) begin
      for (int i = 1; i < N_SRC; i++) begin
        if (w_strb[i / 8]) source_enable_regs[i] <= w_data[i];
      end
    end
  end
  // read channel, one outstanding read
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= '0;
      s_axi_rresp   <= RESP_OKAY;
    end else begin
      s_axi_arready <= !s_axi_rvalid && !(s_axi_arvalid && s_axi_arready);
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rresp  <= RESP_OKAY;
        case (s_axi_araddr)
          ADDR_ENABLE:  s_axi_rdata <= 32'(source_enable_regs);
          ADDR_REQUEST: s_axi_rdata <= 32'(request_latch_regs);
          ADDR_STATUS: begin
            s_axi_rdata <= '0;
            s_axi_rdata[ST_MASTER_BIT] <= master_irq_gate;
            s_axi_rdata[ST_HALT_BIT]   <= halt_latch_flag;
            s_axi_rdata[ST_RESET_BIT]  <= in_reset;
            s_axi_rdata[ST_PEND_BIT]   <= |fwd;
            s_axi_rdata[ST_BACKUP_BIT] <= backup_flag;
          end
          ADDR_VECTOR:  s_axi_rdata <= {16'h0000, irq_vector};
          default: begin
            s_axi_rdata <= '0;
            s_axi_rresp <= RESP_SLVERR;
          end
        endcase
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

endmodule : hric_ctrl

// ==== hric_pkg.sv ====
package hric_pkg;

  // source count and split between pins and peripherals
  localparam int N_SRC = 17;
  localparam int N_EXT = 4;
  localparam int N_INT = 13;

  // source index, also the priority order (0 is highest)
  localparam int SRC_WATCHDOG = 0;
  localparam int SRC_MELODY   = 1;
  localparam int SRC_PORT_B   = 2;
  localparam int SRC_SPEECH   = 3;
  localparam int SRC_PIN_E3   = 4;
  localparam int SRC_PORT_F   = 5;
  localparam int SRC_PORT_0   = 6;

  // entry address per source, two words apart with gaps
  localparam logic [15:0] VEC_TABLE [N_SRC] = '{
    16'h0010, 16'h0012, 16'h0014, 16'h0016, 16'h0018, 16'h001a,
    16'h001e, 16'h0020, 16'h0022, 16'h0024, 16'h0026, 16'h002c,
    16'h002e, 16'h0030, 16'h0032, 16'h0034, 16'h0036};
  localparam logic [15:0] START_ADDR = 16'h0000;

  // least reset pin pulse and its cycle count at 125 MHz
  localparam longint RST_MIN_NS   = 1000000;
  localparam longint CLK_PERIOD_NS = 8;
  localparam int RST_MIN_CYC = int'((RST_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

  // register byte addresses
  localparam logic [7:0] ADDR_ENABLE  = 8'h00;
  localparam logic [7:0] ADDR_REQUEST = 8'h04;
  localparam logic [7:0] ADDR_STATUS  = 8'h08;
  localparam logic [7:0] ADDR_VECTOR  = 8'h0c;

  // status field positions
  localparam int ST_MASTER_BIT = 0;
  localparam int ST_HALT_BIT   = 1;
  localparam int ST_RESET_BIT  = 2;
  localparam int ST_PEND_BIT   = 3;
  localparam int ST_BACKUP_BIT = 4;

  localparam logic [N_SRC-1:0] ENABLE_RST = '0;
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [2:0] {
    HRIC_RESET,
    HRIC_RUN,
    HRIC_HALT,
    HRIC_MEL_STEP,
    HRIC_MEL_XFER
  } hric_state_t;

endpackage : hric_pkg

// ==== hric_monitor.sv ====
`timescale 1ns/1ns
module hric_monitor
  import hric_pkg::*;
#(
  parameter int RST_HOLD_CYC = RST_MIN_CYC
) (
  input wire logic        sys_clk,
  input wire logic        arst_n,
  input wire logic        reset_pin,
  input wire logic        power_on_det,
  input wire logic        osc_stop_det,
  input wire logic        irq_accept,
  input wire logic        cpu_irq,
  input wire logic [15:0] irq_vector,
  input wire logic        cpu_run,
  input wire logic        pc_hold,
  input wire logic        fetch_start,
  input wire logic [15:0] fetch_addr,
  input wire logic        cpu_init,
  input wire logic        melody_xfer,
  input wire logic        halt_latch_flag,
  input wire logic        master_irq_gate,
  input wire logic        backup_flag,
  input wire logic        backup_on,
  input wire logic        bias_reference_supply,
  input wire logic        seg_off_gnd
);
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!arst_n);

  // fetch leaves reset at the zero address only
  chk_fetch_zero_addr: assert property (fetch_start |-> fetch_addr == START_ADDR)
    else $error("fetch started away from the zero address");
  // halt entry stops the core one cycle later
  chk_halt_stops_core: assert property ($rose(halt_latch_flag) |=> !cpu_run && pc_hold)
    else $error("core still running after halt entry");
  // any cause forces the whole reset output set next edge
  chk_reset_outputs: assert property ((reset_pin || power_on_det || osc_stop_det) |=>
    cpu_init && backup_flag && backup_on && bias_reference_supply && seg_off_gnd)
    else $error("reset outputs missing after a reset cause");
  chk_reset_clears_flags: assert property (cpu_init |-> !master_irq_gate && !halt_latch_flag)
    else $error("gate or halt flag set during reset");
  // accept clears the gate even if a return lands in the same cycle
  chk_accept_clears: assert property (irq_accept && cpu_irq |=> !master_irq_gate && !cpu_irq)
    else $error("gate or request survived an accept");
  chk_gate_forward: assert property
    (cpu_irq && irq_vector != VEC_TABLE[SRC_WATCHDOG] |-> $past(master_irq_gate))
    else $error("maskable request forwarded with gate closed");
  chk_vector_area: assert property (cpu_irq |-> irq_vector inside {[16'h0010:16'h0036]} && !irq_vector[0])
    else $error("vector outside the entry area");
  chk_melody_step: assert property
    (melody_xfer |-> halt_latch_flag && ($past(cpu_run) || $past(cpu_run, 2)))
    else $error("melody transfer without step or outside halt");

  cover property ($rose(halt_latch_flag));
  cover property (melody_xfer);
  cover property (irq_accept && cpu_irq);
endmodule : hric_monitor

bind hric_ctrl hric_monitor #(.RST_HOLD_CYC(RST_HOLD_CYC)) u_hric_monitor (
  .sys_clk(sys_clk), .arst_n(arst_n), .reset_pin(reset_pin), .power_on_det(power_on_det),
  .osc_stop_det(osc_stop_det), .irq_accept(irq_accept), .cpu_irq(cpu_irq), .irq_vector(irq_vector),
  .cpu_run(cpu_run), .pc_hold(pc_hold), .fetch_start(fetch_start), .fetch_addr(fetch_addr),
  .cpu_init(cpu_init), .melody_xfer(melody_xfer), .halt_latch_flag(halt_latch_flag),
  .master_irq_gate(master_irq_gate), .backup_flag(backup_flag), .backup_on(backup_on),
  .bias_reference_supply(bias_reference_supply), .seg_off_gnd(seg_off_gnd));

// ==== hric_core_model.sv ====
`timescale 1ns/1ns
module hric_core_model
  import hric_pkg::*;
(
  input  wire logic        sys_clk,
  input  wire logic        arst_n,
  input  wire logic        accept_en,
  input  wire logic        cpu_irq,
  input  wire logic [15:0] irq_vector,
  output logic             irq_accept,
  output logic             return_from_interrupt_instr
);
  logic [15:0] seen [$];
  logic [3:0]  cnt;
  logic        busy;
  logic        slow;

  // takes requests promptly and slowly in turn, returns after a short routine
  always @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      irq_accept <= 1'b0;
      return_from_interrupt_instr <= 1'b0;
      cnt <= 4'h0;
      busy <= 1'b0;
      slow <= 1'b0;
    end else begin
      irq_accept <= 1'b0;
      return_from_interrupt_instr <= 1'b0;
      cnt <= cnt + 4'h1;
      if (busy) begin
        if (cnt == 4'h6) begin
          return_from_interrupt_instr <= 1'b1;
          busy <= 1'b0;
          cnt <= 4'h0;
        end
      end else if (!accept_en || !cpu_irq) begin
        cnt <= 4'h0;
      end else if (cnt >= (slow ? 4'h3 : 4'h0)) begin
        irq_accept <= 1'b1;
        seen.push_back(irq_vector);
        busy <= 1'b1;
        cnt <= 4'h0;
        slow <= !slow;
      end
    end
  end
endmodule : hric_core_model

// ==== hric_tb.sv ====
`timescale 1ns/1ns
module tb;
  import hric_pkg::*;
  localparam int HOLD = 4;
  logic        sys_clk = 1'b0, arst_n = 1'b0, rst_pin = 1'b0, pwr_det = 1'b0, osc_det = 1'b0;
  logic [16:0] src = '0;
  logic        mel = 1'b0, halt_st = 1'b0, en_i = 1'b0, dis_i = 1'b0, acc_en = 1'b1;
  logic        acc, ret_instr, irq, run, pc_hold, fstart, init, mxfer, halt_f, gate, bflag, bon, bias, seg;
  logic [15:0] vec, faddr;
  logic [7:0]  awaddr = '0, araddr = '0;
  logic [31:0] wdata = '0, rdata;
  logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic        awready, wready, bvalid, arready, rvalid;
  logic [1:0]  bresp, rresp;
  int          num_errors = 0, total_checks = 0, cyc = 0;

  hric_ctrl #(.RST_HOLD_CYC(HOLD)) u_hric_ctrl (
    .sys_clk(sys_clk), .arst_n(arst_n), .reset_pin(rst_pin), .power_on_det(pwr_det), .osc_stop_det(osc_det),
    .port_b_group({2'b00, src[2], 1'b0}), .port_e_bit3(src[4]), .port_f_group({src[5], 3'b000}),
    .port_zero_group({3'b000, src[6]}), .watchdog_request(src[0]), .melody_end_request(src[1]),
    .speech_request(src[3]), .timer_zero_request(src[7]), .timer_one_request(src[8]),
    .timer_two_request(src[9]), .timer_three_request(src[10]), .shifter_request(src[11]),
    .ten_hertz_request(src[12]), .thirty_two_hertz_request(src[13]), .sixteen_hertz_request(src[14]),
    .four_hertz_request(src[15]), .two_hertz_request(src[16]), .melody_data_request(mel),
    .halt_second_machine_state(halt_st), .irq_accept(acc), .return_from_interrupt_instr(ret_instr),
    .enable_instr(en_i),
    .disable_instr(dis_i), .cpu_irq(irq), .irq_vector(vec), .cpu_run(run), .pc_hold(pc_hold),
    .fetch_start(fstart), .fetch_addr(faddr), .cpu_init(init), .melody_xfer(mxfer), .halt_latch_flag(halt_f),
    .master_irq_gate(gate), .backup_flag(bflag), .backup_on(bon), .bias_reference_supply(bias),
    .seg_off_gnd(seg), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready));

  hric_core_model u_hric_core_model (.sys_clk(sys_clk), .arst_n(arst_n), .accept_en(acc_en), .cpu_irq(irq),
    .irq_vector(vec), .irq_accept(acc), .return_from_interrupt_instr(ret_instr));

  always #4 sys_clk = ~sys_clk;

  // hang guard, far above the few hundred cycles the run needs
  always @(posedge sys_clk) begin
    cyc++;
    if (cyc == 20000) begin
      num_errors++;
      end_sim();
    end
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  // values read right after an edge are those that edge sampled
  task automatic wait_hi(ref logic s);
    while (s !== 1'b1) @(posedge sys_clk);
  endtask : wait_hi

  task automatic wait_seen(input int n);
    while (u_hric_core_model.seen.size() < n) @(posedge sys_clk);
  endtask : wait_seen

  task automatic strobe(input int which);
    @(posedge sys_clk);
    {halt_st, en_i, dis_i} <= 3'b100 >> which;
    @(posedge sys_clk);
    {halt_st, en_i, dis_i} <= 3'b000;
  endtask : strobe

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge sys_clk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (!bvalid);
    bready <= 1'b0;
    chk(bresp, RESP_OKAY);
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
    @(posedge sys_clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge sys_clk);
      if (arready) arvalid <= 1'b0;
    end while (!rvalid);
    rready <= 1'b0;
    chk(rresp, er);
    if (er === RESP_OKAY) chk(rdata, ed);
  endtask : rd

  task end_sim;
    if (num_errors == 0 && total_checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : end_sim

  initial begin
    repeat (20) @(posedge sys_clk);
    chk({init, bflag, bon, bias, seg, pc_hold, gate, halt_f}, 8'hfc);
    arst_n <= 1'b1;
    wait_hi(fstart);
    chk(faddr, START_ADDR);
    rd(ADDR_ENABLE, 32'h0, RESP_OKAY);
    rd(8'h10, 32'h0, RESP_SLVERR);
    // all seventeen at once: order of service must follow the entry address
    wr(ADDR_ENABLE, 32'h0001_fffe);
    rd(ADDR_ENABLE, 32'h0001_fffe, RESP_OKAY);
    strobe(1);
    @(posedge sys_clk) src <= '1;
    wait_seen(17);
    for (int i = 0; i < 17; i++) chk(u_hric_core_model.seen[i], VEC_TABLE[i]);
    chk(u_hric_core_model.seen[2], 16'h0014);
    chk(u_hric_core_model.seen[4], 16'h0018);
    chk(u_hric_core_model.seen[5], 16'h001a);
    chk(u_hric_core_model.seen[6], 16'h001e);
    chk(u_hric_core_model.seen[16], 16'h0036);
    src <= '0;
    rd(ADDR_REQUEST, 32'h0, RESP_OKAY);
    // masked source latches but is not forwarded; watchdog ignores the gate
    wr(ADDR_ENABLE, 32'h0);
    src[7] <= 1'b1;
    repeat (6) @(posedge sys_clk);
    chk(irq, 1'b0);
    rd(ADDR_REQUEST, 32'h80, RESP_OKAY);
    wr(ADDR_REQUEST, 32'h80);
    strobe(2);
    src <= 17'h1;
    wait_seen(18);
    chk(u_hric_core_model.seen[17], 16'h0010);
    // let the routine's return reopen the gate before closing it for the halt test
    wait_hi(gate);
    // halt, a foreign request, a melody step, then release with gate closed
    src <= '0;
    wr(ADDR_ENABLE, 32'h100);
    strobe(2);
    strobe(0);
    repeat (3) @(posedge sys_clk);
    chk({halt_f, run, pc_hold}, 3'b101);
    src[9] <= 1'b1;
    repeat (6) @(posedge sys_clk);
    chk(halt_f, 1'b1);
    @(posedge sys_clk) mel <= 1'b1;
    @(posedge sys_clk) mel <= 1'b0;
    wait_hi(mxfer);
    repeat (4) @(posedge sys_clk);
    chk({halt_f, run}, 2'b10);
    src[8] <= 1'b1;
    repeat (6) @(posedge sys_clk);
    chk({halt_f, run, irq}, 3'b010);
    wr(ADDR_REQUEST, 32'h0001_ffff);
    // halt while a request stands acts as an idle step
    src <= '0;
    wr(ADDR_ENABLE, 32'h80);
    acc_en <= 1'b0;
    strobe(1);
    src[7] <= 1'b1;
    wait_hi(irq);
    strobe(0);
    repeat (3) @(posedge sys_clk);
    chk(halt_f, 1'b0);
    acc_en <= 1'b1;
    wait_seen(19);
    chk(u_hric_core_model.seen[18], 16'h0020);
    wr(ADDR_STATUS, 32'h10);
    chk(bflag, 1'b0);
    strobe(0);
    repeat (3) @(posedge sys_clk);
    chk(halt_f, 1'b1);
    // each reset cause in turn, the first while halted
    for (int k = 0; k < 3; k++) begin
      @(posedge sys_clk) {osc_det, pwr_det, rst_pin} <= 3'b001 << k;
      repeat (HOLD + 2) @(posedge sys_clk);
      chk({init, halt_f, gate, run, bflag, bon, bias, seg}, 8'h8f);
      {osc_det, pwr_det, rst_pin} <= 3'b000;
      wait_hi(fstart);
      chk(faddr, START_ADDR);
    end
    rd(ADDR_ENABLE, 32'h0, RESP_OKAY);
    end_sim();
  end
endmodule : tb
